// ==== rtl/wake_cfg_pkg.sv ====
// Package: offsets, field positions, reset values and types of the wake configuration registers
package wake_cfg_pkg;

  // ----------------------------------------------------------------
  // Register addresses (7-bit register interface)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
  localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
  localparam logic [6:0] ADDR_PULL = 7'h08;
  localparam logic [6:0] ADDR_FILTER = 7'h09;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int INT_T2_BIT = 7;
  localparam int INT_T1_BIT = 6;
  localparam int INT_WD_BIT = 2;
  localparam int EXT_SCOPE_BIT = 7;
  localparam int EXT_MEAS_BIT = 5;
  localparam int EXT_EN3_BIT = 2;
  localparam int EXT_EN2_BIT = 1;
  localparam int EXT_EN1_BIT = 0;

  // ----------------------------------------------------------------
  // Writable masks, reset, restart and fail-safe values
  // ----------------------------------------------------------------
  localparam logic [7:0] INT_WR_MASK = 8'hC4;
  localparam logic [7:0] EXT_WR_MASK = 8'hA7;
  localparam logic [7:0] SIX_WR_MASK = 8'h3F;
  localparam logic [7:0] INT_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET = 8'h07;
  localparam logic [7:0] PULL_RESET = 8'h00;
  localparam logic [7:0] FILTER_RESET = 8'h00;
  localparam logic [7:0] INT_RESTART_KEEP = 8'hC0;
  localparam logic [7:0] EXT_RESTART_KEEP = 8'hA7;
  localparam logic [7:0] SIX_RESTART_KEEP = 8'h3F;
  localparam logic [7:0] EXT_FAILSAFE_KEEP = 8'hA0;
  localparam logic [7:0] EXT_FAILSAFE_SET = 8'h07;
  localparam logic [7:0] BUS_FAILSAFE_KEEP = 8'hE0;
  localparam logic [7:0] BUS_FAILSAFE_SET = 8'h01;
  localparam logic [7:0] BUS_CTRL_MASK = 8'h07;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PULL_NONE = 2'h0,
    PULL_DOWN = 2'h1,
    PULL_UP = 2'h2,
    PULL_AUTO = 2'h3
  } pull_sel_t;

  typedef enum logic [1:0] {
    FILT_STATIC_16 = 2'h0,
    FILT_STATIC_64 = 2'h1,
    FILT_CYCLIC_T1 = 2'h2,
    FILT_CYCLIC_T2 = 2'h3
  } filter_sel_t;

  // Decoded per-input configuration
  typedef struct packed {
    logic wake_allow;
    pull_sel_t pull_sel;
    filter_sel_t filter_sel;
    logic filter_long;
    logic cyclic_first;
    logic cyclic_second;
  } input_cfg_t;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_req_t;

endpackage : wake_cfg_pkg

// ==== rtl/wake_input_decode.sv ====
// Per-input decode of wake allow, pull and filter fields
`timescale 1ns/10ps
module wake_input_decode (
  // Raw fields
  input wire logic enable_i,
  input wire logic meas_block_i,
  input wire logic [1:0] pull_i,
  input wire logic [1:0] filter_i,
  // Decoded configuration
  output wake_cfg_pkg::input_cfg_t cfg_o
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Measurement overrides enable
  assign cfg_o.wake_allow = enable_i & ~meas_block_i;
  assign cfg_o.pull_sel = wake_cfg_pkg::pull_sel_t'(pull_i);
  assign cfg_o.filter_sel = wake_cfg_pkg::filter_sel_t'(filter_i);
  assign cfg_o.filter_long = (filter_i == wake_cfg_pkg::FILT_STATIC_64);
  assign cfg_o.cyclic_first = (filter_i == wake_cfg_pkg::FILT_CYCLIC_T1);
  assign cfg_o.cyclic_second = (filter_i == wake_cfg_pkg::FILT_CYCLIC_T2);

endmodule : wake_input_decode

// ==== rtl/wake_source_config_regs.sv ====
// Wake source configuration register bank with restart and fail-safe handling
//
// Operation
// - Internal wake bit 7 enables second cyclic timer as wake source.
// - Internal wake bit 6 enables first cyclic timer as wake source.
// - Reserved bits of the wake registers always read zero.
// - Internal wake bit 2 disables watchdog in stop mode; device may update.
// - External wake bit 7: 0 wake-only interrupt, 1 all status bits.
// - External bit 5 selects measurement; inputs one, two then not wake sources.
// - Measurement runs in normal mode; input one, two levels meaningless.
// - External bits 2,1,0 enable wake inputs three, two, one.
// - Reset loads external wake register with 0x07.
// - Restart keeps scope, measurement and enables; clears reserved bits.
// - Fail-safe forces bus control xxx0 0001 and external x0x0 0111.
// - Pull register: two-bit field per input; none, down, up, auto.
// - Pull and filter clear on reset; restart keeps bits 5:0.
// - Filter register: two-bit field per input, bits 7:6 reserved.
// - Filter codes: static 16 us, static 64 us, cyclic timer one, two.
`timescale 1ns/10ps
module wake_source_config_regs #(
  parameter int NUM_INPUTS = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Soft reset and mode events (one-cycle pulses); normal_mode_i is a level
  input wire logic soft_reset_i,
  input wire logic restart_entry_i,
  input wire logic failsafe_entry_i,
  input wire logic normal_mode_i,
  // Register interface
  input wire wake_cfg_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Bus control register from outside, forced on fail-safe entry
  input wire logic [7:0] bus_ctrl_i,
  output logic [7:0] bus_ctrl_force_o,
  output logic bus_ctrl_force_valid_o,
  // Device update of stop-mode watchdog bit
  input wire logic wd_stop_set_i,
  input wire logic wd_stop_clr_i,
  // Decoded configuration
  output logic second_timer_wake_allow_o,
  output logic first_timer_wake_allow_o,
  output logic stop_watchdog_off_bit_b_o,
  output logic int_scope_all_o,
  output logic input_function_select_o,
  output logic measure_run_o,
  output logic [NUM_INPUTS-1:0] level_valid_o,
  output logic [NUM_INPUTS-1:0] wake_allow_o,
  output logic [2*NUM_INPUTS-1:0] pull_sel_o,
  output logic [2*NUM_INPUTS-1:0] filter_sel_o,
  output logic [NUM_INPUTS-1:0] filter_long_o,
  output logic [NUM_INPUTS-1:0] cyclic_first_o,
  output logic [NUM_INPUTS-1:0] cyclic_second_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] int_wake_r;
  logic [7:0] int_wake_nxt;
  logic [7:0] ext_wake_r;
  logic [7:0] ext_wake_nxt;
  logic [7:0] pull_r;
  logic [7:0] pull_nxt;
  logic [7:0] filter_r;
  logic [7:0] filter_nxt;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_int = req_i.addr == wake_cfg_pkg::ADDR_INT_WAKE;
  wire hit_ext = req_i.addr == wake_cfg_pkg::ADDR_EXT_WAKE;
  wire hit_pull = req_i.addr == wake_cfg_pkg::ADDR_PULL;
  wire hit_filter = req_i.addr == wake_cfg_pkg::ADDR_FILTER;
  wire wr_int = req_i.wr & hit_int;
  wire wr_ext = req_i.wr & hit_ext;
  wire wr_pull = req_i.wr & hit_pull;
  wire wr_filter = req_i.wr & hit_filter;

  wire [7:0] int_wdata = req_i.data & wake_cfg_pkg::INT_WR_MASK;
  wire [7:0] ext_wdata = req_i.data & wake_cfg_pkg::EXT_WR_MASK;
  wire [7:0] six_wdata = req_i.data & wake_cfg_pkg::SIX_WR_MASK;

  // ----------------------------------------------------------------
  // Internal wake control next value
  // ----------------------------------------------------------------
  // Device update of bit 2 beats a software write in the same cycle
  wire [7:0] int_wr_val = wr_int ? int_wdata : int_wake_r;
  wire wd_bit_nxt = wd_stop_set_i ? 1'b1 :
                    wd_stop_clr_i ? 1'b0 : int_wr_val[wake_cfg_pkg::INT_WD_BIT];
  wire [7:0] int_upd = {int_wr_val[7:3], wd_bit_nxt, int_wr_val[1:0]};
  // Restart keeps timer enables, bit 2 cleared
  wire [7:0] int_restart = int_wake_r & wake_cfg_pkg::INT_RESTART_KEEP;
  assign int_wake_nxt = soft_reset_i ? wake_cfg_pkg::INT_RESET :
                        restart_entry_i ? int_restart :
                        int_upd & wake_cfg_pkg::INT_WR_MASK;

  // ----------------------------------------------------------------
  // External wake control next value
  // ----------------------------------------------------------------
  // Restart keeps writable bits, reserved cleared
  wire [7:0] ext_restart = ext_wake_r & wake_cfg_pkg::EXT_RESTART_KEEP;
  // Fail-safe forces all three inputs enabled
  wire [7:0] ext_failsafe = (ext_wake_r & wake_cfg_pkg::EXT_FAILSAFE_KEEP) |
                            wake_cfg_pkg::EXT_FAILSAFE_SET;
  // Reset pattern, then fail-safe, restart, write
  assign ext_wake_nxt = soft_reset_i ? wake_cfg_pkg::EXT_RESET :
                        failsafe_entry_i ? ext_failsafe :
                        restart_entry_i ? ext_restart :
                        wr_ext ? ext_wdata : ext_wake_r;

  // ----------------------------------------------------------------
  // Pull and filter next values
  // ----------------------------------------------------------------
  // Clear on reset, keep 5:0 on restart
  assign pull_nxt = soft_reset_i ? wake_cfg_pkg::PULL_RESET :
                    restart_entry_i ? (pull_r & wake_cfg_pkg::SIX_RESTART_KEEP) :
                    wr_pull ? six_wdata : pull_r;
  // Filter register layout, bits 7:6 held zero
  assign filter_nxt = soft_reset_i ? wake_cfg_pkg::FILTER_RESET :
                      restart_entry_i ? (filter_r & wake_cfg_pkg::SIX_RESTART_KEEP) :
                      wr_filter ? six_wdata : filter_r;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      int_wake_r <= wake_cfg_pkg::INT_RESET;
      ext_wake_r <= wake_cfg_pkg::EXT_RESET;
      pull_r <= wake_cfg_pkg::PULL_RESET;
      filter_r <= wake_cfg_pkg::FILTER_RESET;
    end else begin
      int_wake_r <= int_wake_nxt;
      ext_wake_r <= ext_wake_nxt;
      pull_r <= pull_nxt;
      filter_r <= filter_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reserved bits read zero; unmapped reads zero
  wire [7:0] rd_sel = hit_int ? (int_wake_r & wake_cfg_pkg::INT_WR_MASK) :
                      hit_ext ? (ext_wake_r & wake_cfg_pkg::EXT_WR_MASK) :
                      hit_pull ? (pull_r & wake_cfg_pkg::SIX_WR_MASK) :
                      hit_filter ? (filter_r & wake_cfg_pkg::SIX_WR_MASK) : 8'h00;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o <= req_i.rd ? rd_sel : rdata_o;
      rvalid_o <= req_i.rd;
    end
  end

  // ----------------------------------------------------------------
  // Bus control forcing
  // ----------------------------------------------------------------
  // Bus wake enable itself lives in the bus control register, set by software
  // Forced bus control value
  wire [7:0] bus_force_val = (bus_ctrl_i & wake_cfg_pkg::BUS_FAILSAFE_KEEP) |
                             wake_cfg_pkg::BUS_FAILSAFE_SET;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bus_ctrl_force_o <= 8'h00;
      bus_ctrl_force_valid_o <= 1'b0;
    end else begin
      bus_ctrl_force_o <= failsafe_entry_i ? bus_force_val : bus_ctrl_force_o;
      bus_ctrl_force_valid_o <= failsafe_entry_i & ~soft_reset_i;
    end
  end

  // ----------------------------------------------------------------
  // Per-input decode
  // ----------------------------------------------------------------
  // Outputs follow the next-state values so they stay flopped yet current
  wire meas_nxt = ext_wake_nxt[wake_cfg_pkg::EXT_MEAS_BIT];
  wake_cfg_pkg::input_cfg_t cfg_w [NUM_INPUTS];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_input
      // Per-input enable, inputs one and two blocked by measurement
      wake_input_decode u_decode (
        .enable_i(ext_wake_nxt[gi]),
        .meas_block_i(meas_nxt & (gi < 2)),
        .pull_i(pull_nxt[2*gi+1:2*gi]),
        .filter_i(filter_nxt[2*gi+1:2*gi]),
        .cfg_o(cfg_w[gi])
      );
      always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          wake_allow_o[gi] <= wake_cfg_pkg::EXT_RESET[gi];
          pull_sel_o[2*gi+1:2*gi] <= 2'h0;
          filter_sel_o[2*gi+1:2*gi] <= 2'h0;
          filter_long_o[gi] <= 1'b0;
          cyclic_first_o[gi] <= 1'b0;
          cyclic_second_o[gi] <= 1'b0;
          level_valid_o[gi] <= 1'b1;
        end else begin
          wake_allow_o[gi] <= cfg_w[gi].wake_allow;
          pull_sel_o[2*gi+1:2*gi] <= cfg_w[gi].pull_sel;
          filter_sel_o[2*gi+1:2*gi] <= cfg_w[gi].filter_sel;
          filter_long_o[gi] <= cfg_w[gi].filter_long;
          // Cyclic modes need a timer on a switch; not checked here
          cyclic_first_o[gi] <= cfg_w[gi].cyclic_first;
          cyclic_second_o[gi] <= cfg_w[gi].cyclic_second;
          // Levels of inputs one, two invalid in measurement
          level_valid_o[gi] <= ~(meas_nxt & (gi < 2));
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Global configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      second_timer_wake_allow_o <= 1'b0;
      first_timer_wake_allow_o <= 1'b0;
      stop_watchdog_off_bit_b_o <= 1'b0;
      int_scope_all_o <= 1'b0;
      input_function_select_o <= 1'b0;
      measure_run_o <= 1'b0;
    end else begin
      second_timer_wake_allow_o <= int_wake_nxt[wake_cfg_pkg::INT_T2_BIT];
      first_timer_wake_allow_o <= int_wake_nxt[wake_cfg_pkg::INT_T1_BIT];
      stop_watchdog_off_bit_b_o <= int_wake_nxt[wake_cfg_pkg::INT_WD_BIT];
      int_scope_all_o <= ext_wake_nxt[wake_cfg_pkg::EXT_SCOPE_BIT];
      input_function_select_o <= meas_nxt;
      measure_run_o <= meas_nxt & normal_mode_i;
    end
  end

endmodule : wake_source_config_regs

// ==== bench/wake_cfg_monitor.sv ====
// Checker of the wake configuration register bank port behaviour
`timescale 1ns/10ps
module wake_cfg_monitor #(
  parameter int NUM_INPUTS = 3
) (
  // Clock, reset and events
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic soft_reset_i,
  input wire logic restart_entry_i,
  input wire logic failsafe_entry_i,
  input wire logic wd_stop_set_i,
  input wire logic wd_stop_clr_i,
  // Register interface
  input wire wake_cfg_pkg::reg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [7:0] bus_ctrl_i,
  input wire logic [7:0] bus_ctrl_force_o,
  input wire logic bus_ctrl_force_valid_o,
  // Decoded configuration
  input wire logic second_timer_wake_allow_o,
  input wire logic first_timer_wake_allow_o,
  input wire logic stop_watchdog_off_bit_b_o,
  input wire logic int_scope_all_o,
  input wire logic input_function_select_o,
  input wire logic [NUM_INPUTS-1:0] level_valid_o,
  input wire logic [NUM_INPUTS-1:0] wake_allow_o,
  input wire logic [2*NUM_INPUTS-1:0] pull_sel_o,
  input wire logic [2*NUM_INPUTS-1:0] filter_sel_o,
  input wire logic [NUM_INPUTS-1:0] filter_long_o,
  input wire logic [NUM_INPUTS-1:0] cyclic_first_o,
  input wire logic [NUM_INPUTS-1:0] cyclic_second_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // Writes only count when no mode event overrides them
  sequence quiet_s; !soft_reset_i && !restart_entry_i && !failsafe_entry_i; endsequence
  sequence int_wr_s;
    req_i.wr && req_i.addr == 7'h06 && !wd_stop_set_i && !wd_stop_clr_i ##0 quiet_s;
  endsequence
  sequence ext_wr_s; req_i.wr && req_i.addr == 7'h07 ##0 quiet_s; endsequence
  sequence pull_wr_s; req_i.wr && req_i.addr == 7'h08 ##0 quiet_s; endsequence

  int_write_a: assert property (int_wr_s |=>
    second_timer_wake_allow_o == $past(req_i.data[7]) && first_timer_wake_allow_o ==
    $past(req_i.data[6]) && stop_watchdog_off_bit_b_o == $past(req_i.data[2]))
    else $error("internal wake write not reflected");
  ext_write_a: assert property (ext_wr_s |=>
    int_scope_all_o == $past(req_i.data[7]) &&
    input_function_select_o == $past(req_i.data[5]) && wake_allow_o[2] == $past(req_i.data[2]))
    else $error("external wake write not reflected");
  pull_write_a: assert property (pull_wr_s |=> pull_sel_o == $past(req_i.data[5:0]))
    else $error("pull write not reflected");
  meas_block_a: assert property (input_function_select_o |->
    wake_allow_o[1:0] == 2'b00 && level_valid_o[1:0] == 2'b00)
    else $error("measurement does not block inputs one and two");
  filter_code_a: assert property (filter_long_o[2] == (filter_sel_o[5:4] == 2'h1) &&
    cyclic_first_o[2] == (filter_sel_o[5:4] == 2'h2) &&
    cyclic_second_o[2] == (filter_sel_o[5:4] == 2'h3)) else $error("filter code decode wrong");
  soft_reset_a: assert property (soft_reset_i |=> wake_allow_o == 3'h7 &&
    pull_sel_o == 6'h00 && filter_sel_o == 6'h00 && !int_scope_all_o)
    else $error("soft reset values wrong");
  fail_force_a: assert property (failsafe_entry_i && !soft_reset_i |=>
    bus_ctrl_force_valid_o && wake_allow_o[2] &&
    bus_ctrl_force_o == (($past(bus_ctrl_i) & 8'hE0) | 8'h01))
    else $error("fail-safe forcing wrong");
  force_cause_a: assert property (bus_ctrl_force_valid_o |-> $past(failsafe_entry_i))
    else $error("bus control forced without fail-safe entry");
  restart_keep_a: assert property (restart_entry_i && !soft_reset_i &&
    !failsafe_entry_i && !req_i.wr && !wd_stop_set_i |=> $stable(pull_sel_o) &&
    $stable(filter_sel_o) && $stable(wake_allow_o) && !stop_watchdog_off_bit_b_o)
    else $error("restart retention wrong");
  int_rsv_a: assert property (rvalid_o && $past(req_i.addr) == 7'h06 |->
    (rdata_o & 8'h3B) == 8'h00) else $error("internal reserved bits read nonzero");
  ext_rsv_a: assert property (rvalid_o && $past(req_i.addr) == 7'h07 |->
    (rdata_o & 8'h58) == 8'h00) else $error("external reserved bits read nonzero");
endmodule : wake_cfg_monitor

bind wake_source_config_regs wake_cfg_monitor #(.NUM_INPUTS(NUM_INPUTS)) wake_cfg_monitor_inst (
  .clock_i, .rst_i, .soft_reset_i, .restart_entry_i, .failsafe_entry_i, .wd_stop_set_i,
  .wd_stop_clr_i, .req_i, .rdata_o, .rvalid_o, .bus_ctrl_i, .bus_ctrl_force_o,
  .bus_ctrl_force_valid_o, .second_timer_wake_allow_o, .first_timer_wake_allow_o,
  .stop_watchdog_off_bit_b_o, .int_scope_all_o, .input_function_select_o, .level_valid_o,
  .wake_allow_o, .pull_sel_o, .filter_sel_o, .filter_long_o, .cyclic_first_o, .cyclic_second_o);

// ==== bench/wake_source_config_regs_tb.sv ====
// Self-checking bench for the wake configuration register bank
`timescale 1ns/10ps
module wake_source_config_regs_tb;
  // ----------------------------------------------------------------
  // Signals, clock and design
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic soft_reset_i = 1'b0, restart_entry_i = 1'b0, failsafe_entry_i = 1'b0;
  logic normal_mode_i = 1'b0, wd_stop_set_i = 1'b0, wd_stop_clr_i = 1'b0;
  wake_cfg_pkg::reg_req_t req_i = '0;
  logic [7:0] bus_ctrl_i = 8'h00;
  logic [7:0] rdata_o, bus_ctrl_force_o;
  logic rvalid_o, bus_ctrl_force_valid_o, second_timer_wake_allow_o, first_timer_wake_allow_o;
  logic stop_watchdog_off_bit_b_o, int_scope_all_o, input_function_select_o, measure_run_o;
  logic [2:0] level_valid_o, wake_allow_o, filter_long_o, cyclic_first_o, cyclic_second_o;
  logic [5:0] pull_sel_o, filter_sel_o;
  int failures = 0;
  int total_checks = 0;

  always #25 clock_i = ~clock_i;

  wake_source_config_regs wake_source_config_regs_inst (.clock_i, .rst_i, .soft_reset_i,
    .restart_entry_i, .failsafe_entry_i, .normal_mode_i, .req_i, .rdata_o, .rvalid_o,
    .bus_ctrl_i, .bus_ctrl_force_o, .bus_ctrl_force_valid_o, .wd_stop_set_i, .wd_stop_clr_i,
    .second_timer_wake_allow_o, .first_timer_wake_allow_o, .stop_watchdog_off_bit_b_o,
    .int_scope_all_o, .input_function_select_o, .measure_run_o, .level_valid_o, .wake_allow_o,
    .pull_sel_o, .filter_sel_o, .filter_long_o, .cyclic_first_o, .cyclic_second_o);

  task finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clock_i);
    req_i <= '0;
    #1;
  endtask : wr

  task rd(input logic [6:0] a, input logic [7:0] exp);
    int n;
    @(posedge clock_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge clock_i);
    req_i <= '0;
    #1;
    n = 0;
    while (rvalid_o !== 1'b1 && n < 4) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (rvalid_o !== 1'b1) begin
      chk("rvalid", 8'h01, {7'h00, rvalid_o});
      finish_test();
    end else begin
      chk("rdata", exp, rdata_o);
    end
  endtask : rd

  // Event pulses: 0 soft reset, 1 restart, 2 fail-safe, 3 watchdog set, 4 watchdog clear
  task ev(input int k);
    @(posedge clock_i);
    case (k)
      0: soft_reset_i <= 1'b1;
      1: restart_entry_i <= 1'b1;
      2: failsafe_entry_i <= 1'b1;
      3: wd_stop_set_i <= 1'b1;
      default: wd_stop_clr_i <= 1'b1;
    endcase
    @(posedge clock_i);
    {soft_reset_i, restart_entry_i, failsafe_entry_i, wd_stop_set_i, wd_stop_clr_i} <= 5'h00;
    #1;
  endtask : ev

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd(7'h06, 8'h00);
    rd(7'h07, 8'h07);
    rd(7'h08, 8'h00);
    rd(7'h09, 8'h00);
    chk("wake_allow", 8'h07, {5'h00, wake_allow_o});
  endtask : t_reset

  // All ones everywhere, including reserved and unmapped places
  task t_fields;
    wr(7'h06, 8'hFF);
    wr(7'h07, 8'hFF);
    wr(7'h08, 8'hFF);
    wr(7'h09, 8'hFF);
    wr(7'h0A, 8'hFF);
    rd(7'h06, 8'hC4);
    rd(7'h07, 8'hA7);
    rd(7'h08, 8'h3F);
    rd(7'h09, 8'h3F);
    rd(7'h0A, 8'h00);
    chk("timers", 8'h07, {5'h00, second_timer_wake_allow_o, first_timer_wake_allow_o,
      stop_watchdog_off_bit_b_o});
    chk("wake_allow", 8'h04, {5'h00, wake_allow_o});
    chk("level_valid", 8'h04, {5'h00, level_valid_o});
    chk("meas_scope", 8'h07, {5'h00, input_function_select_o, measure_run_o,
      int_scope_all_o});
    @(posedge clock_i);
    normal_mode_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk("measure_run", 8'h00, {7'h00, measure_run_o});
    @(posedge clock_i);
    normal_mode_i <= 1'b1;
  endtask : t_fields

  // Distinct codes per input show field order and codes 1 to 3
  task t_codes;
    wr(7'h07, 8'h05);
    chk("wake_allow", 8'h05, {5'h00, wake_allow_o});
    wr(7'h08, 8'h1B);
    // Timers taken as on a switch
    wr(7'h09, 8'h1B);
    chk("pull_sel", 8'h1B, {2'h0, pull_sel_o});
    chk("filter_sel", 8'h1B, {2'h0, filter_sel_o});
    chk("filter_kind", 8'h22, {2'h0, filter_long_o, cyclic_first_o});
    chk("cyclic_two", 8'h01, {5'h00, cyclic_second_o});
  endtask : t_codes

  task t_restart;
    wr(7'h06, 8'hFF);
    wr(7'h07, 8'hA2);
    wr(7'h08, 8'h2D);
    wr(7'h09, 8'h36);
    ev(1);
    rd(7'h06, 8'hC0);
    rd(7'h07, 8'hA2);
    rd(7'h08, 8'h2D);
    rd(7'h09, 8'h36);
  endtask : t_restart

  task t_failsafe;
    @(posedge clock_i);
    bus_ctrl_i <= 8'hFA;
    ev(2);
    chk("force_valid", 8'h01, {7'h00, bus_ctrl_force_valid_o});
    chk("force_value", 8'hE1, bus_ctrl_force_o);
    rd(7'h07, 8'hA7);
    wr(7'h07, 8'h20);
    ev(2);
    rd(7'h07, 8'h27);
  endtask : t_failsafe

  // Device update of the stop-mode bit, also against a same-edge write
  task t_watchdog;
    wr(7'h06, 8'h00);
    ev(3);
    rd(7'h06, 8'h04);
    ev(4);
    rd(7'h06, 8'h00);
    @(posedge clock_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: 7'h06, data: 8'h00};
    wd_stop_set_i <= 1'b1;
    @(posedge clock_i);
    req_i <= '0;
    wd_stop_set_i <= 1'b0;
    #1;
    rd(7'h06, 8'h04);
  endtask : t_watchdog

  initial begin
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    normal_mode_i <= 1'b1;
    bus_ctrl_i <= 8'h01;
    #1;
    t_reset();
    t_fields();
    t_codes();
    t_restart();
    t_failsafe();
    t_watchdog();
    ev(0);
    t_reset();
    finish_test();
  end
endmodule : wake_source_config_regs_tb
